//--- dds_decoder.sv
// Top of the decoder: link sampling, framing, command decode and the register slave.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module dds_decoder
  import dds_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  // Serial link pins.
  input  wire logic              i_sclk,
  input  wire logic              i_sync_n,
  input  wire logic              i_serial_in,
  input  wire logic              i_chain_mode_enable,
  input  wire logic              i_async_clear_n,
  output logic                   o_serial_out,
  output logic                   o_serial_out_oe_n,
  // Converter side.
  output logic      [CODE_W-1:0] o_dac_a_code,
  output logic      [CODE_W-1:0] o_dac_b_code,
  output dds_pd_mode_t           o_pd_a_mode,
  output dds_pd_mode_t           o_pd_b_mode,
  // APB slave.
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr
);

  logic [3:0]         pins_s;
  logic               sclk_s;
  logic               sync_n_s;
  logic               serial_in_s;
  logic               chain_mode_enable_s;
  logic               sclk_d_r;
  logic               sync_n_d_r;
  logic               sclk_fall;
  logic               sync_rise;
  logic               clr_meta_r;
  logic               clr_sync_r;
  logic               hold_clear;
  logic [FRAME_W-1:0] shift_r;
  logic [4:0]         cnt_r;
  logic [FRAME_W-1:0] frame_r;
  logic               exec_r;
  logic               pend_r;
  logic               accept_en_r;
  logic               serial_out_r;
  logic               serial_oe_n_r;
  dds_chan_cmd_t      cmd_a;
  dds_chan_cmd_t      cmd_b;
  dds_pd_mode_t       pd_mode;
  logic [CODE_W-1:0]  in_a;
  logic [CODE_W-1:0]  in_b;
  logic [31:0]        prdata_r;
  logic               pready_r;
  logic               pslverr_r;
  logic               addr_hit;
  logic               apb_write;
  logic [31:0]        rd_word;

  // All checks in this module run on the system clock and sleep through reset.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // Every link pin but the clear passes two flip-flops before any logic looks at it.
  dds_sync #(
    .WIDTH   (4),
    .RST_VAL (RST_PINS)
  ) u_pin_sync (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    ({i_sclk, i_sync_n, i_serial_in, i_chain_mode_enable}),
    .o_q    (pins_s)
  );

  assign sclk_s   = pins_s[3];
  assign sync_n_s = pins_s[2];
  assign serial_in_s   = pins_s[1];
  assign chain_mode_enable_s   = pins_s[0];

  // Delayed copies give the edges of the sampled link clock and frame sync.
  // They reset to the idle levels, so leaving reset shows no edge on either line.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sclk_d_r   <= 1'b1;
      sync_n_d_r <= 1'b1;
    end else begin
      sclk_d_r   <= sclk_s;
      sync_n_d_r <= sync_n_s;
    end
  end

  assign sclk_fall = sclk_d_r & ~sclk_s;
  assign sync_rise = ~sync_n_d_r & sync_n_s;

  // Clear asserts asynchronously and releases after two clean edges.
  always_ff @(posedge i_mclk or negedge i_async_clear_n) begin
    if (!i_async_clear_n) begin
      clr_meta_r <= 1'b0;
      clr_sync_r <= 1'b0;
    end else begin
      clr_meta_r <= 1'b1;
      clr_sync_r <= clr_meta_r;
    end
  end

  assign hold_clear = ~clr_sync_r;

  // Shift register and bit count; a high frame sync restarts the frame.
  always_ff @(posedge i_mclk) begin
    if (i_rst || hold_clear) begin
      shift_r <= '0;
      cnt_r   <= '0;
    end else if (sync_n_s) begin
      cnt_r <= '0;
    end else if (sclk_fall && (chain_mode_enable_s || cnt_r != FRAME_BITS)) begin
      // Without chaining, edges after the sixteenth are ignored so the frame stays put.
      shift_r <= {shift_r[FRAME_W-2:0], serial_in_s};
      if (cnt_r != FRAME_BITS) begin
        cnt_r <= cnt_r + 5'h1;
      end
    end
  end

  // Frame capture and the one-cycle execute pulse.
  always_ff @(posedge i_mclk) begin
    if (i_rst || hold_clear) begin
      frame_r <= '0;
      exec_r  <= 1'b0;
    end else begin
      exec_r <= 1'b0;
      if (!sync_n_s && sclk_fall && cnt_r == FRAME_BITS - 5'h1 && !chain_mode_enable_s && !pend_r) begin
        frame_r <= {shift_r[FRAME_W-2:0], serial_in_s};
        exec_r  <= accept_en_r;
      end else if (sync_rise && cnt_r == FRAME_BITS && (sync_n_d_r == 1'b0) && (chain_mode_enable_s || pend_r)) begin
        frame_r <= shift_r;
        exec_r  <= accept_en_r;
      end
    end
  end

  // A clear leaves updates waiting for the next rising frame sync.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pend_r <= 1'b0;
    end else if (hold_clear) begin
      pend_r <= 1'b1;
    end else if (sync_rise) begin
      pend_r <= 1'b0;
    end
  end

  // The echo output drives only while chaining and inside a frame.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      serial_out_r  <= 1'b0;
      serial_oe_n_r <= 1'b1;
    end else begin
      serial_out_r  <= shift_r[FRAME_W-1];
      serial_oe_n_r <= ~(chain_mode_enable_s & ~sync_n_s);
    end
  end

  assign o_serial_out      = serial_out_r;
  assign o_serial_out_oe_n = serial_oe_n_r;

  // Both resistor-less codes float the output, so 00 and 11 share one state.
  always_comb begin
    unique case (frame_r[PD_MODE_HI:PD_MODE_LO])
      2'h1:    pd_mode = DDS_PD_1K;
      2'h2:    pd_mode = DDS_PD_100K;
      default: pd_mode = DDS_PD_HIZ;
    endcase
  end

  // Command decode into per-channel actions for this execute pulse.
  always_comb begin
    cmd_a      = '0;
    cmd_b      = '0;
    cmd_a.mode = pd_mode;
    cmd_b.mode = pd_mode;
    if (exec_r) begin
      if (frame_r[PD_SEL_BIT]) begin
        cmd_a.pd = (frame_r[CMD_HI:CMD_LO] != 2'h2);
        cmd_b.pd = (frame_r[CMD_HI:CMD_LO] != 2'h1);
      end else begin
        unique case (frame_r[CMD_HI:CH_SEL_BIT])
          3'h0: cmd_a.wr_in = 1'b1;
          3'h1: cmd_b.wr_in = 1'b1;
          3'h2: begin
            cmd_a.wr_in  = 1'b1;
            cmd_a.wr_dac = 1'b1;
          end
          3'h3: begin
            cmd_a.wr_in  = 1'b1;
            cmd_a.wr_dac = 1'b1;
            cmd_b.copy   = 1'b1;
          end
          3'h4: begin
            cmd_b.wr_in  = 1'b1;
            cmd_b.wr_dac = 1'b1;
          end
          3'h5: begin
            cmd_b.wr_in  = 1'b1;
            cmd_b.wr_dac = 1'b1;
            cmd_a.copy   = 1'b1;
          end
          3'h6: begin
            cmd_a.wr_in  = 1'b1;
            cmd_a.wr_dac = 1'b1;
            cmd_b.wr_in  = 1'b1;
            cmd_b.wr_dac = 1'b1;
          end
          3'h7: begin
            cmd_a.copy = 1'b1;
            cmd_b.copy = 1'b1;
          end
        endcase
      end
    end
  end

  dds_chan u_chan_a (
    .i_mclk          (i_mclk),
    .i_rst           (i_rst),
    .i_async_clear_n (i_async_clear_n),
    .i_hold_clear    (hold_clear),
    .i_cmd           (cmd_a),
    .i_code          (frame_r[CODE_W-1:0]),
    .o_in_code       (in_a),
    .o_dac_code      (o_dac_a_code),
    .o_pd_mode       (o_pd_a_mode)
  );

  dds_chan u_chan_b (
    .i_mclk          (i_mclk),
    .i_rst           (i_rst),
    .i_async_clear_n (i_async_clear_n),
    .i_hold_clear    (hold_clear),
    .i_cmd           (cmd_b),
    .i_code          (frame_r[CODE_W-1:0]),
    .o_in_code       (in_b),
    .o_dac_code      (o_dac_b_code),
    .o_pd_mode       (o_pd_b_mode)
  );

  // Register read mux; unmapped addresses read zero and flag an error.
  always_comb begin
    addr_hit = 1'b1;
    rd_word  = '0;
    unique case (i_paddr)
      OFS_CTRL:   rd_word[0] = accept_en_r;
      OFS_CHAN_A: begin
        rd_word[CHW_DAC_LO +: CODE_W] = o_dac_a_code;
        rd_word[CHW_IN_LO +: CODE_W]  = in_a;
        rd_word[CHW_PD_LO +: 2]       = o_pd_a_mode;
      end
      OFS_CHAN_B: begin
        rd_word[CHW_DAC_LO +: CODE_W] = o_dac_b_code;
        rd_word[CHW_IN_LO +: CODE_W]  = in_b;
        rd_word[CHW_PD_LO +: 2]       = o_pd_b_mode;
      end
      OFS_STATUS: begin
        rd_word[ST_PEND_BIT]     = pend_r;
        rd_word[ST_ACTIVE_BIT]   = ~sync_n_s;
        rd_word[ST_CNT_LO +: 5]  = cnt_r;
      end
      default:    addr_hit = 1'b0;
    endcase
  end

  assign apb_write = i_psel & i_penable & pready_r & i_pwrite;

  // No wait states: the answer is registered in the setup cycle.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      prdata_r  <= RST_PRDATA;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= i_psel & ~i_penable;
      pslverr_r <= i_psel & ~i_penable & ~addr_hit;
      if (i_psel && !i_penable && !i_pwrite) begin
        prdata_r <= rd_word;
      end
    end
  end

  // Software can stop frames from taking effect without touching the link.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      accept_en_r <= RST_ACCEPT_EN;
    end else if (apb_write && i_paddr == OFS_CTRL) begin
      accept_en_r <= i_pwdata[0];
    end
  end

  assign o_prdata  = prdata_r;
  assign o_pready  = pready_r;
  assign o_pslverr = pslverr_r;

  sequence s_last_bit;
    !sync_n_s && sclk_fall && cnt_r == 5'd15 && !chain_mode_enable_s && !pend_r && accept_en_r && !hold_clear;
  endsequence

  sequence s_exec_cmd(logic [2:0] c);
    exec_r && !frame_r[PD_SEL_BIT] && frame_r[CMD_HI:CH_SEL_BIT] == c && !hold_clear;
  endsequence

  chk_exec_at_16: assert property (s_last_bit |=> exec_r)
    else $error("Frame not executed after sixteenth bit.");
  chk_short_drop: assert property (sync_rise && cnt_r < 5'd16 |=> !exec_r)
    else $error("Short frame had an effect.");
  chk_chain_exec: assert property (sync_rise && chain_mode_enable_s && cnt_r == 5'd16 && accept_en_r && !hold_clear
                                   |=> exec_r && frame_r == $past(shift_r))
    else $error("Chained frame not executed on sync rise.");
  chk_echo_out: assert property (chain_mode_enable_s && !sync_n_s |=> !o_serial_out_oe_n && o_serial_out == $past(shift_r[15]))
    else $error("Echo output wrong in chain mode.");
  chk_store_a: assert property (s_exec_cmd(3'h0) |=> in_a == $past(frame_r[11:0]) && $stable(o_dac_a_code))
    else $error("Store to channel A wrong.");
  chk_update_ab: assert property (s_exec_cmd(3'h3) |=> o_dac_a_code == $past(frame_r[11:0])
                                  && o_dac_b_code == $past(in_b))
    else $error("Update A with copy B wrong.");
  chk_bcast_both: assert property (s_exec_cmd(3'h6) |=> o_dac_a_code == o_dac_b_code
                                   && o_dac_b_code == $past(frame_r[11:0]))
    else $error("Broadcast write wrong.");
  chk_copy_all: assert property (s_exec_cmd(3'h7) |=> o_dac_a_code == $past(in_a) && o_dac_b_code == $past(in_b))
    else $error("Copy of both inputs wrong.");
  chk_pd_only_b: assert property (exec_r && frame_r[15:12] == 4'h9 && frame_r[11:10] == 2'h1 && !hold_clear
                                  |=> o_pd_b_mode == DDS_PD_1K && $stable(o_pd_a_mode))
    else $error("Power-down of channel B wrong.");
  chk_pd_wake: assert property (s_exec_cmd(3'h2) |=> o_pd_a_mode == DDS_PD_NORMAL)
    else $error("Channel A not woken by update.");
  chk_clear_zero: assert property (!i_async_clear_n |-> o_dac_a_code == 12'h000 && o_dac_b_code == 12'h000)
    else $error("Clear did not zero outputs.");
  chk_pend_hold: assert property (pend_r && !sync_rise |=> !exec_r)
    else $error("Update while clear pending.");

endmodule // dds_decoder

//--- dds_pkg.sv
// Shared constants and types of the dual converter serial command decoder.
// How it works
// - Frames are sixteen bits, MSB first, four control bits
// - Shift one bit per falling link clock edge
// - Without chaining, act at bit sixteen; drop short frames
// - Chaining: delayed echo out, execute on sync rise
// - Store code into selected channel input register
// - Pattern 0100 updates channel A input and converter
// - Pattern 0110 updates A, copies B input
// - Pattern 1000 updates channel B input and converter
// - Pattern 1010 updates B, copies A input
// - Pattern 1100 writes code to both channels
// - Pattern 1110 copies both inputs to converters
// - Bit twelve selects power-down; bits eleven, ten impedance
// - Bits fifteen, fourteen choose powered-down channels
// - Converter registers hold unsigned twelve-bit codes
// - Power-up clears registers, outputs at zero scale
// - Clear pin low resets registers without clock
// - After clear, update at next sync rise
package dds_pkg;

  localparam int          CODE_W        = 12;
  localparam int          FRAME_W       = 16;
  localparam logic [4:0]  FRAME_BITS    = 5'h10;
  localparam int          PD_SEL_BIT    = 12;
  localparam int          CH_SEL_BIT    = 13;
  localparam int          PD_MODE_HI    = 11;
  localparam int          PD_MODE_LO    = 10;
  localparam int          CMD_HI        = 15;
  localparam int          CMD_LO        = 14;

  // Register map, byte addresses on the bus.
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_CHAN_A    = 8'h04;
  localparam logic [7:0]  OFS_CHAN_B    = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;
  localparam logic [31:0] RST_PRDATA    = 32'h0000_0000;
  localparam logic        RST_ACCEPT_EN = 1'b1;
  localparam logic [11:0] RST_CODE      = 12'h000;
  // Link pins at their idle levels: clock high, frame sync high, data and chaining low.
  localparam logic [3:0]  RST_PINS      = 4'hC;

  // Field positions inside the channel and status words.
  localparam int          CHW_DAC_LO    = 0;
  localparam int          CHW_IN_LO     = 16;
  localparam int          CHW_PD_LO     = 28;
  localparam int          ST_PEND_BIT   = 0;
  localparam int          ST_ACTIVE_BIT = 1;
  localparam int          ST_CNT_LO     = 2;

  typedef enum logic [1:0] {
    DDS_PD_NORMAL = 2'h0,
    DDS_PD_1K     = 2'h1,
    DDS_PD_100K   = 2'h2,
    DDS_PD_HIZ    = 2'h3
  } dds_pd_mode_t;

  typedef struct packed {
    logic         wr_in;
    logic         wr_dac;
    logic         copy;
    logic         pd;
    dds_pd_mode_t mode;
  } dds_chan_cmd_t;

endpackage

//--- dds_sync.sv
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
module dds_sync
  import dds_pkg::*;
#(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // The first stage feeds only the second, so metastability never reaches logic.
  // Reset goes to the idle level of the pins, so no false edge follows release.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta_r <= RST_VAL;
      q_r    <= RST_VAL;
    end else begin
      meta_r <= i_d;
      q_r    <= meta_r;
    end
  end

  assign o_q = q_r;

endmodule // dds_sync

//--- dds_chan.sv
// One converter channel: input register, converter register and power-down state.
`timescale 1ns/1ps
module dds_chan
  import dds_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_async_clear_n,
  input  wire logic              i_hold_clear,
  input  wire dds_chan_cmd_t     i_cmd,
  input  wire logic [CODE_W-1:0] i_code,
  output logic      [CODE_W-1:0] o_in_code,
  output logic      [CODE_W-1:0] o_dac_code,
  output dds_pd_mode_t           o_pd_mode
);

  logic [CODE_W-1:0] in_r;
  logic [CODE_W-1:0] dac_r;
  dds_pd_mode_t      pd_r;

  // The clear pin acts at once; the synchronised hold keeps it until release.
  always_ff @(posedge i_mclk or negedge i_async_clear_n) begin
    if (!i_async_clear_n) begin
      in_r  <= RST_CODE;
      dac_r <= RST_CODE;
      pd_r  <= DDS_PD_NORMAL;
    end else if (i_rst || i_hold_clear) begin
      in_r  <= RST_CODE;
      dac_r <= RST_CODE;
      pd_r  <= DDS_PD_NORMAL;
    end else begin
      if (i_cmd.wr_in) begin
        in_r <= i_code;
      end
      // A copy reads the old input value, which is what a separate copy expects.
      if (i_cmd.wr_dac) begin
        dac_r <= i_code;
      end else if (i_cmd.copy) begin
        dac_r <= in_r;
      end
      if (i_cmd.pd) begin
        pd_r <= i_cmd.mode;
      end else if (i_cmd.wr_dac || i_cmd.copy) begin
        pd_r <= DDS_PD_NORMAL;
      end
    end
  end

  assign o_in_code  = in_r;
  assign o_dac_code = dac_r;
  assign o_pd_mode  = pd_r;

endmodule // dds_chan

//--- dds_host.sv
// Host serial port model that drives command frames onto the converter link.
`timescale 1ns/1ps
module dds_host (
  input  wire logic i_serial_out,
  output logic      o_sclk,
  output logic      o_sync_n,
  output logic      o_serial_in
);
  // The link clock idles high and stands still between frames.
  initial begin
    o_sclk      = 1'b1;
    o_sync_n    = 1'b1;
    o_serial_in = 1'b1;
  end

  // Shifts n bits MSB first, one per falling edge, and leaves sync low.
  // The echo is sampled just before each fall, when the previous shift has long settled.
  task automatic send(input logic [31:0] data, input int n, output logic [15:0] echo);
    echo = 16'h0000;
    // Start off the system clock edge so no pin change races the synchroniser.
    #10;
    o_sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_in = data[i];
      #200;
      echo = {echo[14:0], i_serial_out};
      o_sclk = 1'b0;
      #200;
      o_sclk = 1'b1;
    end
    // A released data line shows the inverse, so a stale bit cannot pass for a real one.
    o_serial_in = ~o_serial_in;
  endtask

  // Ends the frame; sync then stays high long enough for the framing to re-arm.
  task automatic stop();
    #100;
    o_sync_n = 1'b1;
    #400;
  endtask
endmodule // dds_host

//--- tb_dual_dac_serial_command_decoder.sv
// Self-checking bench of the dual converter serial command decoder.
`timescale 1ns/1ps
module tb_dual_dac_serial_command_decoder
  import dds_pkg::*;
;
  logic               i_mclk;
  logic               i_rst;
  logic               i_chain_mode_enable;
  logic               i_async_clear_n;
  logic               i_psel;
  logic               i_penable;
  logic               i_pwrite;
  logic [ADDR_W-1:0]  i_paddr;
  logic [31:0]        i_pwdata;
  logic [31:0]        o_prdata;
  logic               o_pready;
  logic               o_pslverr;
  logic               sclk;
  logic               sync_n;
  logic               sdi;
  logic               o_serial_out;
  logic               o_serial_out_oe_n;
  logic [CODE_W-1:0]  o_dac_a_code;
  logic [CODE_W-1:0]  o_dac_b_code;
  dds_pd_mode_t       o_pd_a_mode;
  dds_pd_mode_t       o_pd_b_mode;
  logic [31:0]        rd;
  logic               err;
  logic [15:0]        echo;
  int                 fails;
  int                 n_tests;

  dds_decoder i_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk), .i_sync_n(sync_n), .i_serial_in(sdi),
    .i_chain_mode_enable(i_chain_mode_enable), .i_async_clear_n(i_async_clear_n),
    .o_serial_out(o_serial_out), .o_serial_out_oe_n(o_serial_out_oe_n),
    .o_dac_a_code(o_dac_a_code), .o_dac_b_code(o_dac_b_code),
    .o_pd_a_mode(o_pd_a_mode), .o_pd_b_mode(o_pd_b_mode),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr)
  );

  dds_host i_host (
    .i_serial_out(o_serial_out),
    .o_sclk(sclk),
    .o_sync_n(sync_n),
    .o_serial_in(sdi)
  );

  // System clock, 50 ns period.
  initial i_mclk = 1'b0;
  always #25 i_mclk = ~i_mclk;

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One bus transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_mclk);
      if (o_pready === 1'b1) break;
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k == 20) begin
      fails++;
      final_report();
    end
  endtask

  // Sends one whole frame and waits well past the update latency.
  task automatic frame(input logic [15:0] f);
    i_host.send({16'h0000, f}, 16, echo);
    i_host.stop();
    repeat (10) @(posedge i_mclk);
  endtask

  task automatic check_out(input logic [11:0] a, input logic [11:0] b, input logic [1:0] pa, input logic [1:0] pb);
    chk({20'h0_0000, o_dac_a_code}, {20'h0_0000, a}, "code a");
    chk({20'h0_0000, o_dac_b_code}, {20'h0_0000, b}, "code b");
    chk({30'h0000_0000, o_pd_a_mode}, {30'h0000_0000, pa}, "pd a");
    chk({30'h0000_0000, o_pd_b_mode}, {30'h0000_0000, pb}, "pd b");
  endtask

  task automatic t_reset();
    check_out(12'h000, 12'h000, 2'h0, 2'h0);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "ctrl reset");
  endtask

  // Stores touch only the input registers, then pair updates copy the other side.
  task automatic t_store_pair();
    frame(16'h0123);
    frame(16'h2456);
    check_out(12'h000, 12'h000, 2'h0, 2'h0);
    apb(1'b0, OFS_CHAN_A, 32'h0000_0000);
    chk(rd, 32'h0123_0000, "in a");
    apb(1'b0, OFS_CHAN_B, 32'h0000_0000);
    chk(rd, 32'h0456_0000, "in b");
    frame(16'h6789);
    check_out(12'h789, 12'h456, 2'h0, 2'h0);
    frame(16'hAABC);
    check_out(12'h789, 12'hABC, 2'h0, 2'h0);
    frame(16'h4111);
    check_out(12'h111, 12'hABC, 2'h0, 2'h0);
    frame(16'h8222);
    check_out(12'h111, 12'h222, 2'h0, 2'h0);
    apb(1'b0, OFS_CHAN_A, 32'h0000_0000);
    chk(rd, 32'h0111_0111, "chan a");
  endtask

  task automatic t_all();
    frame(16'hCFFF);
    check_out(12'hFFF, 12'hFFF, 2'h0, 2'h0);
    frame(16'h0001);
    frame(16'h2002);
    frame(16'hE555);
    check_out(12'h001, 12'h002, 2'h0, 2'h0);
  endtask

  // Every channel choice against every impedance code, each undone by a copy-all.
  task automatic t_pd();
    logic [1:0] em;
    for (int c = 0; c < 4; c++) begin
      for (int m = 0; m < 4; m++) begin
        em = (m == 0) ? 2'h3 : 2'(m);
        frame({2'(c), 1'(m), 1'b1, 2'(m), 10'h3FF});
        check_out(12'h001, 12'h002, (c == 2) ? 2'h0 : em, (c == 1) ? 2'h0 : em);
        frame(16'hE000);
        check_out(12'h001, 12'h002, 2'h0, 2'h0);
      end
    end
  endtask

  // Frames are ignored while accepting is off; an unmapped place answers with an error.
  task automatic t_regs();
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    frame(16'hC777);
    check_out(12'h001, 12'h002, 2'h0, 2'h0);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk({31'h0000_0000, err}, 32'h0000_0001, "unmapped wr");
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped rd");
  endtask

  // A short frame is dropped; a long one acts at bit sixteen and ignores the rest.
  task automatic t_short();
    i_host.send(32'h0000_0311, 10, echo);
    i_host.stop();
    repeat (10) @(posedge i_mclk);
    check_out(12'h001, 12'h002, 2'h0, 2'h0);
    i_host.send(32'hC444_C555, 32, echo);
    repeat (10) @(posedge i_mclk);
    check_out(12'h444, 12'h444, 2'h0, 2'h0);
    i_host.stop();
    repeat (10) @(posedge i_mclk);
    check_out(12'h444, 12'h444, 2'h0, 2'h0);
  endtask

  // In chain mode the first word comes back out and only the last word runs, at sync rise.
  task automatic t_chain();
    @(posedge i_mclk);
    i_chain_mode_enable <= 1'b1;
    repeat (6) @(posedge i_mclk);
    chk({31'h0000_0000, o_serial_out_oe_n}, 32'h0000_0001, "oe idle");
    i_host.send(32'hC333_C0AA, 32, echo);
    repeat (10) @(posedge i_mclk);
    check_out(12'h444, 12'h444, 2'h0, 2'h0);
    chk({16'h0000, echo}, 32'h0000_C333, "echo");
    i_host.stop();
    repeat (10) @(posedge i_mclk);
    check_out(12'h0AA, 12'h0AA, 2'h0, 2'h0);
    i_chain_mode_enable <= 1'b0;
    repeat (6) @(posedge i_mclk);
  endtask

  // Clear acts without a clock; afterwards nothing updates before the next sync rise.
  task automatic t_clear();
    frame(16'h1400);
    @(posedge i_mclk);
    i_async_clear_n <= 1'b0;
    #2;
    check_out(12'h000, 12'h000, 2'h0, 2'h0);
    repeat (3) @(posedge i_mclk);
    i_async_clear_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    apb(1'b0, OFS_CHAN_A, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "chan a clr");
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "clear pending");
    i_host.send(32'h0000_C321, 16, echo);
    repeat (10) @(posedge i_mclk);
    check_out(12'h000, 12'h000, 2'h0, 2'h0);
    i_host.stop();
    repeat (10) @(posedge i_mclk);
    check_out(12'h321, 12'h321, 2'h0, 2'h0);
  endtask

  // Main sequence: reset for eight cycles, then every scenario in turn.
  initial begin
    fails = 0;
    n_tests = 0;
    i_rst = 1'b1;
    i_chain_mode_enable = 1'b0;
    i_async_clear_n = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0000_0000;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    t_reset();
    t_store_pair();
    t_all();
    t_pd();
    t_regs();
    t_short();
    t_chain();
    t_clear();
    final_report();
  end
endmodule // tb_dual_dac_serial_command_decoder
